// >>> logic/gccb_pkg.sv
`default_nettype none
package gccb_pkg;

  // ---------------------------------------------------------------
  // Device-wide figures
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_TOTAL    = 20;
  localparam int unsigned CTRL_PER_SIDE = 5;
  localparam int unsigned LOOP_OUTS     = 5;
  localparam int unsigned PIN_COUNT     = 2;

  // ---------------------------------------------------------------
  // Source codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SRC_PIN0  = 3'h0;
  localparam logic [2:0] SRC_PIN1  = 3'h1;
  localparam logic [2:0] SRC_CTRA  = 3'h2;
  localparam logic [2:0] SRC_CTRB  = 3'h3;
  localparam logic [2:0] SRC_DPCLK = 3'h4;
  localparam logic [2:0] SRC_LOGIC = 3'h5;

  localparam logic [1:0] STATIC_DYN   = 2'h0;
  localparam logic [1:0] STATIC_DPCLK = 2'h1;
  localparam logic [1:0] STATIC_LOGIC = 2'h2;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CFG  = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;

  localparam int unsigned CFG_W       = 11;
  localparam int unsigned CFG_SEL_LSB = 0;
  localparam int unsigned CFG_OFF_BIT = 2;
  localparam int unsigned CFG_IDA_LSB = 3;
  localparam int unsigned CFG_IDB_LSB = 6;
  localparam int unsigned CFG_REF_BIT = 9;
  localparam int unsigned CFG_MAN_BIT = 10;
  localparam logic [CFG_W-1:0] CFG_RST = 11'h008;

  localparam int unsigned CTRL_USER_BIT = 0;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_PARK,
    ST_ARM
  } gccb_state_t;

endpackage
`default_nettype wire

// >>> logic/gccb_sync.sv
`timescale 1ns/100ps
`default_nettype none
module gccb_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // ---------------------------------------------------------------
  // Three stages, change taken once stages two and three agree
  // ---------------------------------------------------------------
  genvar i;
  for (i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        s1_q[i]     <= 1'b0;
        s2_q[i]     <= 1'b0;
        s3_q[i]     <= 1'b0;
        sync_out[i] <= 1'b0;
      end
      else if (ce)
      begin
        s1_q[i] <= async_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i])
          sync_out[i] <= s3_q[i];
      end
    end
  end

endmodule
`default_nettype wire

// >>> logic/gccb_top.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module gccb_top #(
  parameter int unsigned BLOCK_INDEX = 0,
  parameter int unsigned ADDR_W      = 8
) (
  // Clock, reset, enable
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  // APB slave
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Clock sources
  input  wire logic [1:0]           clk_pin,
  input  wire logic [4:0]           loop_counter,
  input  wire logic                 dpclk_pin,
  input  wire logic                 logic_src,
  // User logic controls
  input  wire logic [1:0]           clk_select,
  input  wire logic                 net_enable,
  input  wire logic                 ref_switch,
  // Outputs
  output var  logic                 global_clock_net,
  output var  logic                 net_to_loop,
  output var  logic                 loop_input_clock
);

  // ---------------------------------------------------------------
  // Source synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pin_s;
  logic [4:0] ctr_s;
  logic       dp_s;

  gccb_sync #(.WIDTH(8)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in ({dpclk_pin, loop_counter, clk_pin}),
    .sync_out ({dp_s, ctr_s, pin_s})
  );

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [gccb_pkg::CFG_W-1:0] cfg_q;
  logic                       user_q;
  logic                       en_q;
  logic                       prev_q;
  logic [2:0]                 cur_q;
  gccb_pkg::gccb_state_t      st_q;
  logic                       net_d;

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  wire [1:0] static_sel_w = cfg_q[gccb_pkg::CFG_SEL_LSB +: 2];
  wire       static_off_w = cfg_q[gccb_pkg::CFG_OFF_BIT];
  wire [2:0] ida_w        = cfg_q[gccb_pkg::CFG_IDA_LSB +: 3];
  wire [2:0] idb_w        = cfg_q[gccb_pkg::CFG_IDB_LSB +: 3];
  wire       manual_w     = cfg_q[gccb_pkg::CFG_MAN_BIT];

  // Two of the loop's five counters, one loop only
  wire ctra_w = (ida_w < 3'(gccb_pkg::LOOP_OUTS))
                ? ctr_s[ida_w] : 1'b0;
  wire ctrb_w = (idb_w < 3'(gccb_pkg::LOOP_OUTS))
                ? ctr_s[idb_w] : 1'b0;

  // Six sources, indexed by source code
  wire [5:0] src_v = {logic_src, dp_s, ctrb_w, ctra_w, pin_s};

  // Target source: static choices override runtime select
  wire [2:0] req_w =
    (static_sel_w == gccb_pkg::STATIC_DPCLK) ? gccb_pkg::SRC_DPCLK :
    (static_sel_w == gccb_pkg::STATIC_LOGIC) ? gccb_pkg::SRC_LOGIC :
    {1'b0, clk_select};

  wire cur_lvl_w = src_v[cur_q];
  wire new_lvl_w = src_v[req_w];
  wire fall_w    = prev_q & ~cur_lvl_w;
  wire loop_ok_w = (cur_q < gccb_pkg::SRC_DPCLK);

  // Loop reference switch
  wire refsw_w = manual_w ? ref_switch
                          : cfg_q[gccb_pkg::CFG_REF_BIT];

  // ---------------------------------------------------------------
  // Block position, out-of-range index reads zero
  // ---------------------------------------------------------------
  wire [7:0] blk_w = (BLOCK_INDEX < gccb_pkg::CTRL_TOTAL)
                     ? 8'(BLOCK_INDEX) : 8'h00;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire [7:0] addr_w  = 8'(paddr);
  wire       setup_w = psel & ~penable;
  wire       acc_w   = psel & penable & ce;
  wire       hit_cfg = (addr_w == gccb_pkg::OFF_CFG);
  wire       hit_ctl = (addr_w == gccb_pkg::OFF_CTRL);
  wire       hit_st  = (addr_w == gccb_pkg::OFF_STAT);
  wire       bad_w   = ~(hit_cfg | hit_ctl | hit_st)
                     | (pwrite & hit_cfg & user_q)
                     | (pwrite & hit_st);
  wire       wr_cfg  = acc_w & pwrite & hit_cfg & ~user_q;
  wire       wr_ctl  = acc_w & pwrite & hit_ctl;

  wire [31:0] rd_w =
    hit_cfg ? {{(32-gccb_pkg::CFG_W){1'b0}}, cfg_q} :
    hit_ctl ? {31'h0, user_q} :
    hit_st  ? {blk_w, 17'h0, net_d, loop_ok_w,
               (st_q != gccb_pkg::ST_RUN), en_q, cur_q} :
    32'h0;

  assign pready  = ce;
  assign pslverr = psel & penable & bad_w;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (ce && setup_w)
      prdata <= rd_w;
  end

  // ---------------------------------------------------------------
  // Configuration and user mode
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q  <= gccb_pkg::CFG_RST;
      user_q <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= pwdata[gccb_pkg::CFG_W-1:0];
      if (wr_ctl && pwdata[gccb_pkg::CTRL_USER_BIT])
        user_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Enable, sampled at the source's falling edge
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q   <= 1'b0;
      prev_q <= 1'b0;
    end
    else if (ce)
    begin
      prev_q <= cur_lvl_w;
      if (fall_w)
        en_q <= net_enable;
    end
  end

  // ---------------------------------------------------------------
  // Glitch-free source switch
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= gccb_pkg::ST_RUN;
      cur_q <= gccb_pkg::SRC_PIN0;
    end
    else if (ce)
    begin
      case (st_q)
        gccb_pkg::ST_RUN:
          if (req_w != cur_q)
            st_q <= gccb_pkg::ST_PARK;
        gccb_pkg::ST_PARK:
          if (!cur_lvl_w)
            st_q <= gccb_pkg::ST_ARM;
        gccb_pkg::ST_ARM:
          if (!new_lvl_w)
          begin
            cur_q <= req_w;
            st_q  <= gccb_pkg::ST_RUN;
          end
        default:
          st_q <= gccb_pkg::ST_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Network and loop outputs
  // ---------------------------------------------------------------
  always_comb
  begin
    net_d = 1'b0;
    if (en_q && !static_off_w && st_q != gccb_pkg::ST_ARM)
      net_d = cur_lvl_w;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      global_clock_net <= 1'b0;
      net_to_loop      <= 1'b0;
      loop_input_clock <= 1'b0;
    end
    else if (ce)
    begin
      global_clock_net <= net_d;
      net_to_loop      <= loop_ok_w & net_d;
      // Only dedicated pins reach the loop input
      loop_input_clock <= refsw_w ? pin_s[1] : pin_s[0];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  static_off_a: assert property (
    ce && static_off_w |=> !global_clock_net)
    else $error("network active while statically off");
  en_off_a: assert property (
    ce && !en_q |=> !global_clock_net)
    else $error("network edge while disabled");
  en_edge_a: assert property (
    $changed(en_q) |-> $past(fall_w && ce))
    else $error("enable changed away from falling edge");
  cfg_lock_a: assert property (
    user_q |=> $stable(cfg_q))
    else $error("static settings changed in user mode");
  arm_low_a: assert property (
    ce && st_q == gccb_pkg::ST_ARM |=> !global_clock_net)
    else $error("network high while switching");
  sel_take_a: assert property (
    ce && st_q == gccb_pkg::ST_ARM && !new_lvl_w
    |=> cur_q == $past(req_w) ##0 st_q == gccb_pkg::ST_RUN)
    else $error("new source not taken");
  loop_guard_a: assert property (
    ce && cur_q >= gccb_pkg::SRC_DPCLK |=> !net_to_loop)
    else $error("loop fed from dpclk or logic");
  ref_pick_a: assert property (
    ce && refsw_w |=> loop_input_clock == $past(pin_s[1]))
    else $error("reference switch not followed");
  logic_static_a: assert property (
    ce && st_q == gccb_pkg::ST_RUN
    && static_sel_w == gccb_pkg::STATIC_LOGIC
    && cur_q != gccb_pkg::SRC_LOGIC
    |=> st_q == gccb_pkg::ST_PARK)
    else $error("static logic selection not applied");
  net_follow_a: assert property (
    ce && en_q && !static_off_w && st_q != gccb_pkg::ST_ARM
    |=> global_clock_net == $past(cur_lvl_w))
    else $error("enabled network not following source");
  fall_take_a: assert property (
    ce && fall_w |=> en_q == $past(net_enable))
    else $error("enable not taken at falling edge");
  loop_feed_a: assert property (
    ce && loop_ok_w |=> net_to_loop == $past(net_d))
    else $error("loop feed lost for pin or counter source");
  ref_zero_a: assert property (
    ce && !refsw_w |=> loop_input_clock == $past(pin_s[0]))
    else $error("loop input not from first pin");
  user_stick_a: assert property (
    user_q |=> user_q)
    else $error("user mode left without reset");
  park_wait_a: assert property (
    ce && st_q == gccb_pkg::ST_PARK && cur_lvl_w
    |=> st_q == gccb_pkg::ST_PARK)
    else $error("switch armed while current source high");

endmodule
`default_nettype wire

// >>> verif/gccb_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module gccb_src_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Clock sources
  output wire logic [1:0] clk_pin,
  output wire logic [4:0] loop_counter,
  output wire logic       dpclk_pin,
  output wire logic       logic_src
);
  // ---------------------------------------------------------------
  // Free-running sources, half periods in pclk cycles
  // ---------------------------------------------------------------
  localparam int H [9] = '{4, 6, 5, 7, 8, 11, 9, 8, 3};
  logic [8:0] lvl_q;
  int         cnt_q [9];

  assign clk_pin      = lvl_q[1:0];
  assign loop_counter = lvl_q[6:2];
  assign dpclk_pin    = lvl_q[7];
  assign logic_src    = lvl_q[8];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lvl_q <= '0;
      for (int i = 0; i < 9; i++) cnt_q[i] <= 0;
    end
    else
      for (int i = 0; i < 9; i++)
        if (cnt_q[i] == H[i] - 1)
        begin
          cnt_q[i] <= 0;
          lvl_q[i] <= ~lvl_q[i];
        end
        else
          cnt_q[i] <= cnt_q[i] + 1;
endmodule
`default_nettype wire

// >>> verif/tb_global_clock_control_block.sv
`timescale 1ns/100ps
`default_nettype none
module tb_global_clock_control_block;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err, mon = 0;
  logic [1:0]  clk_pin, clk_select = '0;
  logic [4:0]  loop_counter;
  logic        dpclk_pin, logic_src, net_enable = 1, ref_switch = 0;
  logic        global_clock_net, net_to_loop, loop_input_clock;
  int          n_errors = 0, checked = 0, hrun = 0, hmin = 99;

  always #5 pclk = ~pclk;

  gccb_src_model src (.pclk(pclk), .presetn(presetn), .clk_pin(clk_pin),
    .loop_counter(loop_counter), .dpclk_pin(dpclk_pin),
    .logic_src(logic_src));

  gccb_top #(.BLOCK_INDEX(3)) uut (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_pin(clk_pin), .loop_counter(loop_counter),
    .dpclk_pin(dpclk_pin), .logic_src(logic_src),
    .clk_select(clk_select), .net_enable(net_enable),
    .ref_switch(ref_switch), .global_clock_net(global_clock_net),
    .net_to_loop(net_to_loop), .loop_input_clock(loop_input_clock));

  // Shortest high pulse on the network
  always @(posedge pclk)
    if (global_clock_net === 1'b1)
      hrun <= hrun + 1;
    else
    begin
      if (mon && hrun != 0 && hrun < hmin) hmin <= hrun;
      hrun <= 0;
    end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Rising edges of one output over 240 cycles, one edge of slack
  task automatic ecount(input int which, input int e);
    int n;
    logic p, v;
    n = 0;
    p = 0;
    repeat (240)
    begin
      @(posedge pclk);
      v = (which == 0) ? global_clock_net :
          (which == 1) ? net_to_loop : loop_input_clock;
      if (v === 1'b1 && p === 1'b0) n++;
      p = v;
    end
    check((n >= e - 1 && n <= e + 1) ? e : n, e);
  endtask

  task automatic final_report();
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #500000;
    n_errors++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge pclk);
    check(global_clock_net, 1'b0);
    presetn <= 1'b1;
    apb(0, gccb_pkg::OFF_CFG, 0);
    check(rd, 32'h0000_0008);
    apb(0, gccb_pkg::OFF_STAT, 0);
    check(rd[31:24], 8'h03);
    apb(0, 8'h0c, 0);
    check(err, 1'b1);
    check(rd, 32'h0);
    mon = 1;
    for (int s = 0; s < 4; s++)
    begin
      clk_select <= s[1:0];
      repeat (40) @(posedge pclk);
      apb(0, gccb_pkg::OFF_STAT, 0);
      check(rd[2:0], s[2:0]);
      ecount(0, (s == 0) ? 30 : (s == 1) ? 20 : (s == 2) ? 17 : 24);
    end
    clk_select <= 2'h0;
    @(posedge pclk);
    clk_select <= 2'h3;
    @(posedge pclk);
    clk_select <= 2'h1;
    repeat (60) @(posedge pclk);
    apb(0, gccb_pkg::OFF_STAT, 0);
    check(rd[2:0], 3'h1);
    mon = 0;
    check((hmin >= 4) ? 4 : hmin, 4);
    apb(1, gccb_pkg::OFF_CFG, 32'h0000_0060);
    clk_select <= 2'h2;
    repeat (60) @(posedge pclk);
    ecount(0, 13);
    apb(1, gccb_pkg::OFF_CFG, 32'h0000_0048);
    ecount(0, 17);
    net_enable <= 1'b0;
    repeat (30) @(posedge pclk);
    ecount(0, 0);
    ecount(2, 30);
    net_enable <= 1'b1;
    repeat (30) @(posedge pclk);
    ecount(0, 17);
    apb(1, gccb_pkg::OFF_CFG, 32'h0000_0400);
    ref_switch <= 1'b1;
    repeat (20) @(posedge pclk);
    ecount(2, 20);
    ref_switch <= 1'b0;
    repeat (20) @(posedge pclk);
    ecount(2, 30);
    apb(1, gccb_pkg::OFF_CFG, 32'h0000_0200);
    repeat (20) @(posedge pclk);
    ecount(2, 20);
    apb(1, gccb_pkg::OFF_CFG, 32'h0000_0004);
    repeat (20) @(posedge pclk);
    ecount(0, 0);
    apb(1, gccb_pkg::OFF_CFG, 32'h0000_0002);
    repeat (40) @(posedge pclk);
    apb(0, gccb_pkg::OFF_STAT, 0);
    check(rd[2:0], gccb_pkg::SRC_LOGIC);
    ecount(0, 40);
    ecount(1, 0);
    apb(1, gccb_pkg::OFF_CFG, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    apb(0, gccb_pkg::OFF_STAT, 0);
    check(rd[2:0], gccb_pkg::SRC_DPCLK);
    ecount(1, 0);
    clk_select <= 2'h0;
    apb(1, gccb_pkg::OFF_CFG, 32'h0000_0000);
    repeat (40) @(posedge pclk);
    ecount(1, 30);
    apb(1, gccb_pkg::OFF_CTRL, 32'h0000_0001);
    apb(1, gccb_pkg::OFF_CFG, 32'h0000_0004);
    check(err, 1'b1);
    apb(0, gccb_pkg::OFF_CFG, 0);
    check(rd, 32'h0);
    ecount(0, 30);
    apb(1, gccb_pkg::OFF_STAT, 32'h0000_00ff);
    check(err, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
